// *** hw/wrxmc_pkg.sv ***
// package for the wireless receiver mode control block
package wrxmc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h04;
   localparam logic [7:0] OFS_PACKET  = 8'h08;
   localparam logic [7:0] OFS_LOAD    = 8'h0C;
   // control field positions
   localparam int CTRL_LOOP_BIT = 0;
   localparam int CTRL_OVP_BIT  = 1;
   localparam int CTRL_ATREG_BIT = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // end-transfer packet contents
   localparam logic [7:0] ETP_HEADER   = 8'h02;
   localparam logic [7:0] ETP_UNKNOWN  = 8'h00;
   localparam logic [7:0] ETP_COMPLETE = 8'h01;
   // target voltage codes in millivolts
   localparam logic [15:0] TGT_BAND0 = 16'h1BA8; // 7.08 V
   localparam logic [15:0] TGT_BAND1 = 16'h1888; // 6.28 V
   localparam logic [15:0] TGT_BAND2 = 16'h159A; // 5.53 V
   localparam logic [15:0] TGT_BAND3 = 16'h13F6; // 5.11 V
   // load bands in percent of maximum current
   localparam logic [7:0] BAND_10 = 8'h0A;
   localparam logic [7:0] BAND_20 = 8'h14;
   localparam logic [7:0] BAND_40 = 8'h28;
   // timing
   localparam int CLK_HZ       = 25_000_000;
   localparam int FAST_MS      = 30;
   localparam int SLOW_MS      = 250;
   localparam int FAST_CYCLES  = FAST_MS * (CLK_HZ / 1000);
   localparam int SLOW_CYCLES  = SLOW_MS * (CLK_HZ / 1000);
   // decoded power path modes
   typedef enum logic [1:0] {
      WRXMC_ADAPTER = 2'b00,
      WRXMC_NOLIMIT = 2'b01,
      WRXMC_REVERSE = 2'b10,
      WRXMC_OFF     = 2'b11
   } wrxmc_mode_e;
   // axi4-lite request and answer carriers
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } wrxmc_axi_req_s;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } wrxmc_axi_rsp_s;
   // power path outputs
   typedef struct packed {
      logic        adapter_switch_on;
      logic        wireless_enable;
      logic        wired_enable;
      logic        wireless_priority;
      logic        reverse_boost;
      logic        comm_limit_on;
      logic        regulator_on;
   } wrxmc_path_s;
   // packet request to the modulator
   typedef struct packed {
      logic        valid;
      logic [7:0]  header;
      logic [7:0]  payload;
   } wrxmc_pkt_s;
endpackage : wrxmc_pkg

// *** hw/wrxmc_top.sv ***
// mode decode, packet scheduling and register slave for the receiver control
// How it works
// - pins 00: adapter control, adapter first else wireless, limit on, no end packet
// - pins 01: communication limit off, both sources usable, no end packet
// - pins 10: adapter switch low, wireless off, reverse boost on, reason 0x00
// - pins 11: adapter and wireless off, no output, reason 0x01 charge complete
// - select A low with both sources: select B picks wired or wireless priority
// - default mode: adapter present turns switch on and wireless off, else switch off
// - unconnected selects read low, giving adapter control mode
// - loop active: error packets every 30 ms until on target, then 250 ms
// - overvoltage: regulator off and ask transmitter to lower voltage
// - rectifier target picked from load bands, 7.08 V down to 5.11 V
// - end reasons travel in a packet with header 0x02
`timescale 1ns/100ps
module wrxmc_top
   import wrxmc_pkg::*;
#(
   parameter int FAST_COUNT = FAST_CYCLES,
   parameter int SLOW_COUNT = SLOW_CYCLES
) (
   // clock and reset
   input  wire logic           aclk,
   input  wire logic           aresetn,
   // register bus
   input  wire wrxmc_pkg::wrxmc_axi_req_s axi_req,
   output wrxmc_pkg::wrxmc_axi_rsp_s      axi_rsp,
   // pins and comparators
   input  wire logic           mode_select_a,
   input  wire logic           mode_select_b,
   input  wire logic           adapter_detect,
   input  wire logic           wireless_present,
   // power path
   output wrxmc_pkg::wrxmc_path_s         path,
   output logic [15:0]                    rectifier_target_level,
   // packets to the modulator
   output wrxmc_pkg::wrxmc_pkt_s          pkt,
   input  wire logic           pkt_ready
);
   import wrxmc_pkg::*;

   localparam logic [7:0] HDR_ERROR = 8'h03;

   typedef struct packed {
      logic [2:0]  sync1;
      logic [2:0]  sync2;
      logic [31:0] ctrl;
      logic [7:0]  load_pct;
      logic [7:0]  err_code;
      logic        aw_held;
      logic [7:0]  aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [31:0] timer;
      logic        end_sent;
      logic [7:0]  end_reason;
      logic [7:0]  sent_count;
      wrxmc_path_s path;
      logic [15:0] target;
      wrxmc_pkt_s  pkt;
   } wrxmc_state_s;

   wrxmc_state_s st;
   wrxmc_state_s next_st;
   wrxmc_mode_e  mode;
   logic         sel_a;
   logic         sel_b;
   logic         adapter;

   // target band lookup, used for the live load and for register reads
   function automatic logic [15:0] band_target(input logic [7:0] pct);
      if (pct <= BAND_10) begin
         band_target = TGT_BAND0;
      end else if (pct <= BAND_20) begin
         band_target = TGT_BAND1;
      end else if (pct <= BAND_40) begin
         band_target = TGT_BAND2;
      end else begin
         band_target = TGT_BAND3;
      end
   endfunction : band_target

   // only the second stage is read, the first may be metastable
   assign sel_a   = st.sync2[0];
   assign sel_b   = st.sync2[1];
   assign adapter = st.sync2[2];
   // floating pins come in low through pull-downs, decoding to adapter mode
   assign mode    = wrxmc_mode_e'({sel_a, sel_b});

   // next state
   always_comb begin
      logic aw_now;
      logic w_now;
      logic loop_on;
      logic ovp;
      logic on_target;
      logic [31:0] period;
      aw_now    = 1'b0;
      w_now     = 1'b0;
      next_st   = st;
      next_st.sync1 = {adapter_detect, mode_select_b, mode_select_a};
      next_st.sync2 = st.sync1;
      loop_on   = st.ctrl[CTRL_LOOP_BIT];
      ovp       = st.ctrl[CTRL_OVP_BIT];
      on_target = st.ctrl[CTRL_ATREG_BIT];
      period    = 32'(SLOW_COUNT);
      // write channel capture, either order
      if (axi_req.awvalid && !st.aw_held && !st.bvalid) begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !st.w_held && !st.bvalid) begin
         next_st.w_held = 1'b1;
         next_st.w_data = axi_req.wdata;
      end
      aw_now = st.aw_held;
      w_now  = st.w_held;
      if (aw_now && w_now) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = 2'b00;
         if (st.aw_addr == OFS_CTRL) begin
            next_st.ctrl = st.w_data;
         end else if (st.aw_addr == OFS_LOAD) begin
            next_st.load_pct = st.w_data[7:0];
         end else if (st.aw_addr == OFS_STATUS || st.aw_addr == OFS_PACKET) begin
            next_st.bresp = 2'b00; // read-only, write ignored
         end else begin
            next_st.bresp = 2'b10;
         end
      end
      if (st.bvalid && axi_req.bready) begin
         next_st.bvalid = 1'b0;
      end
      // read channel
      if (axi_req.arvalid && !st.rvalid) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = 2'b00;
         if (axi_req.araddr == OFS_CTRL) begin
            next_st.rdata = st.ctrl;
         end else if (axi_req.araddr == OFS_STATUS) begin
            next_st.rdata = {8'h00, st.sent_count, 7'h00, adapter,
                             1'b0, st.path[6:0]};
         end else if (axi_req.araddr == OFS_PACKET) begin
            next_st.rdata = {8'h00, st.end_reason, st.target};
         end else if (axi_req.araddr == OFS_LOAD) begin
            next_st.rdata = {16'h0000, band_target(st.load_pct)};
         end else begin
            next_st.rdata = 32'h0000_0000;
            next_st.rresp = 2'b10;
         end
      end else if (st.rvalid && axi_req.rready) begin
         next_st.rvalid = 1'b0;
      end
      // power path decode
      next_st.path = '0;
      next_st.path.regulator_on = !ovp;
      case (mode)
         WRXMC_ADAPTER: begin
            next_st.path.comm_limit_on     = 1'b1;
            next_st.path.wired_enable      = 1'b1;
            next_st.path.adapter_switch_on = adapter;
            next_st.path.wireless_enable   = !adapter;
            next_st.path.wireless_priority = 1'b0;
         end
         WRXMC_NOLIMIT: begin
            next_st.path.comm_limit_on     = 1'b0;
            next_st.path.wired_enable      = 1'b1;
            next_st.path.wireless_enable   = 1'b1;
            next_st.path.wireless_priority = 1'b1;
            next_st.path.adapter_switch_on = adapter && !wireless_present;
         end
         WRXMC_REVERSE: begin
            next_st.path.adapter_switch_on = 1'b1; // switch pin low = on
            next_st.path.wired_enable      = 1'b1;
            next_st.path.reverse_boost     = 1'b1;
         end
         WRXMC_OFF: begin
            next_st.path.regulator_on      = 1'b0;
         end
         default: begin
            next_st.path = '0;
         end
      endcase
      // target band, refreshed only while the wireless input is enabled
      if (next_st.path.wireless_enable) begin
         next_st.target = band_target(st.load_pct);
      end
      // packet handshake
      if (st.pkt.valid && pkt_ready) begin
         next_st.pkt.valid = 1'b0;
         next_st.sent_count = st.sent_count + 8'h01;
      end
      // end transfer packet, sent once per entry to a stopping mode
      if (mode == WRXMC_REVERSE || mode == WRXMC_OFF) begin
         next_st.end_reason = (mode == WRXMC_OFF) ? ETP_COMPLETE : ETP_UNKNOWN;
         // a direct move between the two stopping modes owes a fresh packet
         if (next_st.end_reason != st.end_reason) begin
            next_st.end_sent = 1'b0;
         end
         if (!next_st.end_sent && !st.pkt.valid) begin
            next_st.end_sent    = 1'b1;
            next_st.pkt.valid   = 1'b1;
            next_st.pkt.header  = ETP_HEADER;
            next_st.pkt.payload = next_st.end_reason;
         end
         next_st.timer = 32'h0000_0000;
      end else begin
         next_st.end_sent = 1'b0;
         // error packets: fast while off target or in overvoltage, slow once settled
         if (!on_target || ovp) begin
            period = 32'(FAST_COUNT);
         end
         if (loop_on || ovp) begin
            if (st.timer >= period - 32'h1) begin
               next_st.timer = 32'h0000_0000;
               if (!st.pkt.valid) begin
                  next_st.pkt.valid   = 1'b1;
                  next_st.pkt.header  = HDR_ERROR;
                  next_st.pkt.payload = ovp ? 8'h80 : st.err_code; // negative = lower
               end
            end else begin
               next_st.timer = st.timer + 32'h1;
            end
         end else begin
            next_st.timer = 32'h0000_0000;
         end
      end
      next_st.err_code = on_target ? 8'h00 : 8'hF0;
   end

   // registered state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st      <= '0;
         st.ctrl <= CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   // outputs, all from flip-flops
   assign path                   = st.path;
   assign rectifier_target_level = st.target;
   assign pkt                    = st.pkt;
   // one driver for the whole answer; readies come straight from the holding flags and the response valid flags
   assign axi_rsp = '{
      awready: !st.aw_held && !st.bvalid,
      wready:  !st.w_held && !st.bvalid,
      bvalid:  st.bvalid,
      bresp:   st.bresp,
      arready: !st.rvalid,
      rvalid:  st.rvalid,
      rdata:   st.rdata,
      rresp:   st.rresp
   };

   // mode checks
   chk_off_mode_path: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == WRXMC_OFF |=> !path.wireless_enable && !path.regulator_on)
      else $error("off mode left power on");
   chk_reverse_path: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == WRXMC_REVERSE |=> path.reverse_boost && path.adapter_switch_on)
      else $error("reverse mode path wrong");
   chk_adapter_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == WRXMC_ADAPTER |=> path.comm_limit_on
         && path.adapter_switch_on == $past(adapter))
      else $error("adapter mode path wrong");
   chk_wired_first: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == WRXMC_ADAPTER |=> !path.wireless_priority)
      else $error("wired source lost priority");
   chk_nolimit_mode: assert property (@(posedge aclk) disable iff (!aresetn)
      mode == WRXMC_NOLIMIT |=> !path.comm_limit_on && path.wireless_enable)
      else $error("limit not off");
   chk_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(mode_select_a) ##1 mode_select_a |=> sel_a)
      else $error("select a not synchronised in two cycles");
   // packet checks; the launch decision lies one cycle before the rise of valid
   chk_end_header: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pkt.valid) && $past(mode) == WRXMC_OFF
         |-> pkt.header == ETP_HEADER && pkt.payload == ETP_COMPLETE)
      else $error("end packet malformed");
   chk_pkt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      pkt.valid && !pkt_ready
         |=> pkt.valid && $stable(pkt.header) && $stable(pkt.payload))
      else $error("packet changed before it was taken");
   chk_ovp_reg_off: assert property (@(posedge aclk) disable iff (!aresetn)
      st.ctrl[CTRL_OVP_BIT] |=> !path.regulator_on)
      else $error("regulator on in overvoltage");
   chk_ovp_lower: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(pkt.valid) && pkt.header != ETP_HEADER && $past(st.ctrl[CTRL_OVP_BIT])
         |-> pkt.payload == 8'h80)
      else $error("overvoltage packet does not ask for less");
   chk_band_target: assert property (@(posedge aclk) disable iff (!aresetn)
      path.wireless_enable && st.load_pct > BAND_40 && $stable(st.load_pct)
         |=> rectifier_target_level == TGT_BAND3)
      else $error("heavy load target wrong");
   chk_err_timer: assert property (@(posedge aclk) disable iff (!aresetn)
      st.timer <= 32'(SLOW_COUNT))
      else $error("error packet timer overran");
endmodule : wrxmc_top

// *** verification/wrxmc_mod_model.sv ***
// modulator model that takes packets at once or after a stall
`timescale 1ns/100ps
module wrxmc_mod_model (
   // clock and pace
   input  wire logic               aclk,
   input  wire logic               slow,
   // packet port
   input  wire wrxmc_pkg::wrxmc_pkt_s pkt,
   output logic                    pkt_ready = 1'b1,
   // log of what was taken
   output wrxmc_pkg::wrxmc_pkt_s   last = '0,
   output int                      n_pkts = 0,
   output int                      gap = 0
);
   import wrxmc_pkg::*;
   int cyc = 0;
   int at = 0;
   int held = 0;
   // a slow pad keeps ready low for three cycles of every packet
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      held <= (pkt.valid && !pkt_ready) ? held + 1 : 0;
      pkt_ready <= !slow || (pkt.valid && !pkt_ready && held >= 2);
      if (pkt.valid && pkt_ready) begin
         last <= pkt;
         n_pkts <= n_pkts + 1;
         gap <= cyc - at;
         at <= cyc;
      end
   end
endmodule : wrxmc_mod_model

// *** verification/wireless_rx_mode_control_test.sv ***
// scenario bench for the receiver mode control block
`timescale 1ns/100ps
module wireless_rx_mode_control_test;
   import wrxmc_pkg::*;
   // short packet periods keep the run brief
   localparam int F = 20;
   localparam int S = 50;
   localparam logic [7:0]  PCT [6] = '{8'h05, 8'h0A, 8'h0F, 8'h28, 8'h29, 8'h64};
   localparam logic [15:0] TGT [6] = '{TGT_BAND0, TGT_BAND0, TGT_BAND1,
                                       TGT_BAND2, TGT_BAND3, TGT_BAND3};
   logic           aclk = 1'b0;
   logic           aresetn = 1'b0;
   wrxmc_axi_req_s axi_req = '0;
   wrxmc_axi_rsp_s axi_rsp;
   logic           sel_a = 1'b0;
   logic           sel_b = 1'b0;
   logic           adapter = 1'b0;
   logic           wl = 1'b0;
   logic           slow = 1'b0;
   wrxmc_path_s    path;
   logic [15:0]    tgt;
   wrxmc_pkt_s     pkt;
   wrxmc_pkt_s     last;
   logic           pkt_ready;
   int             n_pkts;
   int             gap;
   int             failures = 0;
   int             checked = 0;
   int             cyc = 0;
   logic [31:0]    rd;
   logic [1:0]     rr;
   logic [1:0]     br;

   wrxmc_top #(.FAST_COUNT(F), .SLOW_COUNT(S)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
      .mode_select_a(sel_a), .mode_select_b(sel_b), .adapter_detect(adapter),
      .wireless_present(wl), .path(path), .rectifier_target_level(tgt),
      .pkt(pkt), .pkt_ready(pkt_ready));
   wrxmc_mod_model i_pad (.aclk(aclk), .slow(slow), .pkt(pkt),
      .pkt_ready(pkt_ready), .last(last), .n_pkts(n_pkts), .gap(gap));

   // clock, 40 ns period
   initial begin
      forever #20 aclk = ~aclk;
   end

   // hang guard, far above the few hundred cycles needed
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         complete_run();
      end
   end

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // waits end on falling edges so that outputs have settled
   task tick(input int n);
      repeat (n) @(negedge aclk);
   endtask : tick

   // handshakes are judged on the falling edge, acted on at the next rising edge
   task axi_write(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      @(posedge aclk);
      axi_req.awaddr <= a;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge aclk);
         aw = axi_req.awvalid && axi_rsp.awready;
         w = axi_req.wvalid && axi_rsp.wready;
         b = axi_req.bready && axi_rsp.bvalid;
         br = axi_rsp.bresp;
         @(posedge aclk);
         if (aw) axi_req.awvalid <= 1'b0;
         if (w) axi_req.wvalid <= 1'b0;
         if (b) axi_req.bready <= 1'b0;
      end
   endtask : axi_write

   task axi_read(input logic [7:0] a);
      logic ar, r;
      @(posedge aclk);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      r = 1'b0;
      while (!r) begin
         @(negedge aclk);
         ar = axi_req.arvalid && axi_rsp.arready;
         r = axi_req.rready && axi_rsp.rvalid;
         rd = axi_rsp.rdata;
         rr = axi_rsp.rresp;
         @(posedge aclk);
         if (ar) axi_req.arvalid <= 1'b0;
         if (r) axi_req.rready <= 1'b0;
      end
   endtask : axi_read

   // host pins are driven actively on both levels
   task set_mode(input logic a, input logic b);
      @(posedge aclk);
      sel_a <= a;
      sel_b <= b;
      tick(6);
   endtask : set_mode

   task wait_pkt(input int n);
      for (int t = 0; t < 200 && n_pkts <= n; t++) @(negedge aclk);
   endtask : wait_pkt

   task t_band;
      axi_read(OFS_CTRL);
      check("ctrl reset", rd, CTRL_RESET);
      for (int i = 0; i < 6; i++) begin
         axi_write(OFS_LOAD, {24'h0, PCT[i]});
         check("write resp", br, 2'b00);
         tick(3);
         check("target", tgt, TGT[i]);
      end
      axi_read(OFS_LOAD);
      check("load read", rd[15:0], TGT[5]);
      axi_read(8'h10);
      check("unmapped resp", rr, 2'b10);
      check("unmapped data", rd, 32'h0);
      axi_write(8'h10, 32'h1);
      check("unmapped write", br, 2'b10);
      $display("test bands done");
   endtask : t_band

   task t_modes;
      int n0;
      n0 = n_pkts;
      tick(2);
      check("limit default", path.comm_limit_on, 1'b1);
      check("switch idle", path.adapter_switch_on, 1'b0);
      @(posedge aclk);
      adapter <= 1'b1;
      wl <= 1'b1;
      tick(6);
      check("switch on", path.adapter_switch_on, 1'b1);
      check("wireless off", path.wireless_enable, 1'b0);
      check("wired first", path.wireless_priority, 1'b0);
      check("limit on", path.comm_limit_on, 1'b1);
      @(posedge aclk);
      sel_b <= 1'b1;
      tick(2);
      check("sync delay", path.comm_limit_on, 1'b1);
      tick(4);
      check("wireless first", path.wireless_priority, 1'b1);
      check("limit off", path.comm_limit_on, 1'b0);
      check("wireless wins", path.adapter_switch_on, 1'b0);
      check("both usable", {path.wired_enable, path.wireless_enable}, 2'b11);
      check("no end packet", n_pkts, n0);
      @(posedge aclk);
      adapter <= 1'b0;
      set_mode(1'b0, 1'b0);
      $display("test modes done");
   endtask : t_modes

   // the pad stalls here so each end packet must be held
   task t_end;
      int n0;
      slow <= 1'b1;
      n0 = n_pkts;
      set_mode(1'b1, 1'b0);
      wait_pkt(n0);
      check("end count", n_pkts, n0 + 1);
      check("end header", last.header, ETP_HEADER);
      check("reason unknown", last.payload, ETP_UNKNOWN);
      check("reverse boost", path.reverse_boost, 1'b1);
      check("wireless cut", path.wireless_enable, 1'b0);
      set_mode(1'b0, 1'b0);
      n0 = n_pkts;
      set_mode(1'b1, 1'b1);
      wait_pkt(n0);
      check("end count", n_pkts, n0 + 1);
      check("end header", last.header, ETP_HEADER);
      check("reason done", last.payload, ETP_COMPLETE);
      check("no output", {path.wireless_enable, path.wired_enable, path.regulator_on},
            3'b000);
      axi_read(OFS_PACKET);
      check("last reason", rd[23:16], ETP_COMPLETE);
      axi_read(OFS_STATUS);
      check("status path", rd[8:0], 9'h000);
      check("sent count", rd[23:16], n_pkts[7:0]);
      slow <= 1'b0;
      set_mode(1'b0, 1'b0);
      $display("test end packets done");
   endtask : t_end

   task t_err;
      int n0;
      n0 = n_pkts;
      axi_write(OFS_CTRL, 32'h1);
      wait_pkt(n0 + 1);
      check("fast count", n_pkts, n0 + 2);
      check("fast gap", gap, F);
      check("off target", last.payload, 8'hF0);
      n0 = n_pkts;
      axi_write(OFS_CTRL, 32'h5);
      wait_pkt(n0 + 1);
      check("slow count", n_pkts, n0 + 2);
      check("slow gap", gap, S);
      check("on target", last.payload, 8'h00);
      n0 = n_pkts;
      axi_write(OFS_CTRL, 32'h2);
      wait_pkt(n0 + 1);
      check("ovp count", n_pkts, n0 + 2);
      check("regulator off", path.regulator_on, 1'b0);
      check("lower request", last.payload, 8'h80);
      check("ovp gap", gap, F);
      axi_write(OFS_CTRL, 32'h0);
      $display("test error packets done");
   endtask : t_err

   task complete_run;
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run

   // reset for four cycles, then the scenarios in turn
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_band;
      t_modes;
      t_end;
      t_err;
      complete_run;
   end
endmodule : wireless_rx_mode_control_test
